// ===== verilog/uhis_regs.vh
// register offsets, field positions and reset values of the event status block
`ifndef UHIS_REGS_VH
`define UHIS_REGS_VH

// register byte offsets
`define UHIS_ADDR_W            8
`define UHIS_OFF_CONTROL       8'h04
`define UHIS_OFF_CMD_STATUS    8'h08
`define UHIS_OFF_EVT_STATUS    8'h0c
`define UHIS_OFF_EVT_ENABLE    8'h10
`define UHIS_OFF_EVT_DISABLE   8'h14
`define UHIS_OFF_EVT_CLEAR     8'h18

// event status / enable field positions
`define UHIS_BIT_RESERVED_TOP  31
`define UHIS_BIT_GLOBAL_EN     31
`define UHIS_BIT_OWNER_CHG     30
`define UHIS_BIT_HUB_CHG       6
`define UHIS_BIT_FRAME_WRAP    5
`define UHIS_BIT_FATAL_ERR     4
`define UHIS_BIT_RESUME        3
`define UHIS_BIT_FRAME_START   2
`define UHIS_BIT_DONE_LIST     1
`define UHIS_BIT_SCHED_OVR     0

// control and command status field positions
`define UHIS_BIT_ROUTE_SEL     8
`define UHIS_BIT_OWNER_REQ     3

// frame number bit whose toggle marks a frame count wrap
`define UHIS_FRAME_NUM_W       16
`define UHIS_FRAME_WRAP_SRC    15

// root hub register widths and number of downstream ports
`define UHIS_HUB_REG_W         32
`define UHIS_HUB_PORTS         2

// implemented bits and reset values
`define UHIS_STATUS_MASK       32'h4000_007f
`define UHIS_ENABLE_MASK       32'hc000_007f
`define UHIS_STATUS_RESET      32'h0000_0000
`define UHIS_ENABLE_RESET      32'h0000_0000
`define UHIS_CONTROL_RESET     1'h0
`define UHIS_OWNER_REQ_RESET   1'h0

// size of the shared memory area used for done list exchange
`define UHIS_SHARED_AREA_BYTES 256

`endif

// ===== verilog/uhis_change_det.v
// change detector: one-cycle pulse whenever a watched value changes
`timescale 1ns/1ps

module uhis_change_det #(
    parameter W = 32
) (
    // clock and reset
    input  wire         i_sys_clk,
    input  wire         i_rst,
    // watched value, same clock domain
    input  wire [W-1:0] i_value,
    // change pulse
    output reg          o_changed
);

reg [W-1:0] prev_reg;
reg         armed_reg;

////////////////////////////////////////////////////////////////////////////
// the first sample after reset only loads the history; comparing against
// the reset value would report a change that never happened
always @(posedge i_sys_clk) begin
    if (i_rst) begin
        prev_reg  <= {W{1'b0}};
        armed_reg <= 1'b0;
        o_changed <= 1'b0;
    end else begin
        prev_reg  <= i_value;
        armed_reg <= 1'b1;
        o_changed <= armed_reg & (i_value != prev_reg);
    end
end

endmodule // uhis_change_det

// ===== verilog/uhis_event_status.v
// host controller event status flags, enables and interrupt routing
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "uhis_regs.vh"

module uhis_event_status (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // register port
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wr_data,
    input  wire        i_wr_stb,
    input  wire        i_rd_stb,
    output reg  [31:0] o_rd_data,
    // root hub and frame counter state, same clock domain
    input  wire [31:0] i_hub_status,
    input  wire [31:0] i_hub_port1_status,
    input  wire [31:0] i_hub_port2_status,
    input  wire [15:0] i_frame_number,
    // one-cycle event pulses from the controller core
    input  wire        i_fatal_error,
    input  wire        i_resume_seen,
    input  wire        i_frame_start,
    input  wire        i_done_written,
    input  wire        i_sched_overrun,
    // interrupt outputs, active high levels
    output reg         o_usb_irq,
    output reg         o_mgmt_irq,
    // owner change request level to the ownership logic
    output reg         o_owner_change_request
);

////////////////////////////////////////////////////////////////////////////
// decode helpers

// keeps only the bits that a register really implements
function [31:0] field_mask;
    input [31:0] data;
    input [31:0] mask;
    begin
        field_mask = data & mask;
    end
endfunction

// write strobe hit on one register offset
function wr_hit;
    input [7:0] off;
    begin
        wr_hit = i_wr_stb & (i_addr == off);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// state

reg  [31:0] status_reg;
reg  [31:0] status_next;
reg  [31:0] enable_reg;
reg  [31:0] enable_next;
reg         route_sel_reg;
reg         route_sel_next;
reg         owner_req_next;
reg  [31:0] rd_next;
reg  [31:0] evt_vec;
reg  [31:0] clr_vec;
reg  [31:0] pend_vec;
reg         usb_irq_next;
reg         mgmt_irq_next;

// the hub itself plus each downstream port has one watched status word
localparam HUB_REGS = `UHIS_HUB_PORTS + 1;
localparam HUB_W    = `UHIS_HUB_REG_W;

wire [HUB_REGS*HUB_W-1:0] hub_regs_w;
wire [HUB_REGS-1:0]       hub_changed_w;
wire                      frame_wrap_w;
wire                      owner_req_wr_w;

////////////////////////////////////////////////////////////////////////////
// change detectors on the root hub registers and the frame counter

// status of the hub itself and of ports 1 and 2, one slice each
assign hub_regs_w = {i_hub_port2_status, i_hub_port1_status, i_hub_status};

// one detector per watched word, so a change in any of them is caught
genvar gi;
generate
    for (gi = 0; gi < HUB_REGS; gi = gi + 1) begin : g_hub_det
        uhis_change_det #(
            .W (HUB_W)
        ) u_det (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .i_value   (hub_regs_w[gi*HUB_W +: HUB_W]),
            .o_changed (hub_changed_w[gi])
        );
    end
endgenerate

// only the top frame bit is watched; both edges count as a wrap
// because the counter crosses it once going up and once on roll-over
uhis_change_det #(
    .W (1)
) u_frame_det (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_value   (i_frame_number[`UHIS_FRAME_WRAP_SRC]),
    .o_changed (frame_wrap_w)
);

////////////////////////////////////////////////////////////////////////////
// owner change request written by the driver

// a write of one to the request bit is what starts an ownership change
assign owner_req_wr_w = wr_hit(`UHIS_OFF_CMD_STATUS) &
                        i_wr_data[`UHIS_BIT_OWNER_REQ];

////////////////////////////////////////////////////////////////////////////
// event vector: one bit per event kind; the three hub words share bit 6 and the owner change bit comes from a driver write

// the core pulses are taken on the edge that samples them; hub and frame wrap
// changes come one cycle late, through their change detectors
always @* begin
    evt_vec = 32'h0000_0000;
    evt_vec[`UHIS_BIT_OWNER_CHG]   = owner_req_wr_w;
    evt_vec[`UHIS_BIT_HUB_CHG]     = |hub_changed_w;
    evt_vec[`UHIS_BIT_FRAME_WRAP]  = frame_wrap_w;
    evt_vec[`UHIS_BIT_FATAL_ERR]   = i_fatal_error;
    evt_vec[`UHIS_BIT_RESUME]      = i_resume_seen;
    evt_vec[`UHIS_BIT_FRAME_START] = i_frame_start;
    // pulse comes once the done head sits in the shared area slot
    evt_vec[`UHIS_BIT_DONE_LIST]   = i_done_written;
    evt_vec[`UHIS_BIT_SCHED_OVR]   = i_sched_overrun;
end

////////////////////////////////////////////////////////////////////////////
// software clears: a zero written to the status register or a one
// written to the clear register drops a flag; the clear register spares
// a handler the read-modify-write that could wipe a flag set meanwhile

always @* begin
    clr_vec = 32'h0000_0000;
    if (wr_hit(`UHIS_OFF_EVT_STATUS)) begin
        clr_vec = field_mask(~i_wr_data, `UHIS_STATUS_MASK);
    end else if (wr_hit(`UHIS_OFF_EVT_CLEAR)) begin
        clr_vec = field_mask(i_wr_data, `UHIS_STATUS_MASK);
    end
end

////////////////////////////////////////////////////////////////////////////
// next status: flags are sticky, the set term is or-ed in after the
// clear so an event in the clearing cycle survives

always @* begin
    status_next = (status_reg & ~clr_vec) | evt_vec;
    // bit 31 and bits 29..7 never hold a value, so they read as zero
    status_next = field_mask(status_next, `UHIS_STATUS_MASK);
end

////////////////////////////////////////////////////////////////////////////
// enable register: write one to set, write one to the disable view to
// drop; the global enable sits in bit 31 of the same register
// reserved enable bits are never stored and read back as zero

always @* begin
    enable_next = enable_reg;
    if (wr_hit(`UHIS_OFF_EVT_ENABLE)) begin
        enable_next = enable_reg |
                      field_mask(i_wr_data, `UHIS_ENABLE_MASK);
    end else if (wr_hit(`UHIS_OFF_EVT_DISABLE)) begin
        enable_next = enable_reg &
                      ~field_mask(i_wr_data, `UHIS_ENABLE_MASK);
    end
end

////////////////////////////////////////////////////////////////////////////
// route select and owner change request bits

always @* begin
    route_sel_next = route_sel_reg;
    if (wr_hit(`UHIS_OFF_CONTROL)) begin
        route_sel_next = i_wr_data[`UHIS_BIT_ROUTE_SEL];
    end
end

// the request stays visible until its flag has been handled and cleared
// it tracks flag 30 exactly, so the two can never disagree
always @* begin
    owner_req_next = o_owner_change_request;
    if (owner_req_wr_w) begin
        owner_req_next = 1'b1;
    end else if (~status_next[`UHIS_BIT_OWNER_CHG]) begin
        owner_req_next = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// interrupt routing, computed from next values so the line rises on
// the same edge as the flag that causes it
// the global enable gates both lines; the single enables only pick
// which flags may count towards them

always @* begin
    pend_vec = status_next & enable_next;
    pend_vec[`UHIS_BIT_GLOBAL_EN] = 1'b0;
    usb_irq_next  = 1'b0;
    mgmt_irq_next = 1'b0;
    if (enable_next[`UHIS_BIT_GLOBAL_EN]) begin
        // ownership change always goes to the management line at once
        mgmt_irq_next = pend_vec[`UHIS_BIT_OWNER_CHG];
        pend_vec[`UHIS_BIT_OWNER_CHG] = 1'b0;
        if (route_sel_next) begin
            mgmt_irq_next = mgmt_irq_next | (|pend_vec);
        end else begin
            usb_irq_next = |pend_vec;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read mux; unmapped offsets and the clear register read zero
// the disable view returns the enables too; no read has a side effect

always @* begin
    case (i_addr)
        `UHIS_OFF_CONTROL: begin
            rd_next = 32'h0000_0000;
            rd_next[`UHIS_BIT_ROUTE_SEL] = route_sel_reg;
        end
        `UHIS_OFF_CMD_STATUS: begin
            rd_next = 32'h0000_0000;
            rd_next[`UHIS_BIT_OWNER_REQ] = o_owner_change_request;
        end
        `UHIS_OFF_EVT_STATUS: begin
            rd_next = field_mask(status_reg, `UHIS_STATUS_MASK);
        end
        `UHIS_OFF_EVT_ENABLE: begin
            rd_next = enable_reg;
        end
        `UHIS_OFF_EVT_DISABLE: begin
            rd_next = enable_reg;
        end
        default: begin
            rd_next = 32'h0000_0000;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// control and flag registers; the driver must save the shared done head
// before it clears the done flag, the hardware has no way to check that
// ordering

always @(posedge i_sys_clk) begin
    if (i_rst) begin
        status_reg    <= `UHIS_STATUS_RESET;
        enable_reg    <= `UHIS_ENABLE_RESET;
        route_sel_reg <= `UHIS_CONTROL_RESET;
    end else begin
        status_reg    <= status_next;
        enable_reg    <= enable_next;
        route_sel_reg <= route_sel_next;
    end
end

// outputs straight from flip-flops; the interrupt lines take the next
// values so they never lag the flag that raised them by a cycle
always @(posedge i_sys_clk) begin
    if (i_rst) begin
        o_owner_change_request <= `UHIS_OWNER_REQ_RESET;
        o_usb_irq              <= 1'b0;
        o_mgmt_irq             <= 1'b0;
        o_rd_data              <= 32'h0000_0000;
    end else begin
        o_owner_change_request <= owner_req_next;
        o_usb_irq              <= usb_irq_next;
        o_mgmt_irq             <= mgmt_irq_next;
        // read data stand only in the cycle after the strobe; zero
        // elsewhere lets several slaves share one or-ed read bus
        o_rd_data              <= i_rd_stb ? rd_next : 32'h0000_0000;
    end
end

endmodule // uhis_event_status

// ===== verif/uhis_event_status_props.sv
// concurrent checks on the ports of the event status block
`timescale 1ns/1ps

module uhis_event_status_props (
    // clock, reset and register port
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic        i_wr_stb,
    input wire logic        i_rd_stb,
    input wire logic [31:0] o_rd_data,
    // event pulses and outputs
    input wire logic        i_fatal_error,
    input wire logic        i_resume_seen,
    input wire logic        o_usb_irq,
    input wire logic        o_mgmt_irq,
    input wire logic        o_owner_change_request
);
    logic [31:0] en_m;
    logic        rt_m;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////
    // shadow of enables and route so the irq checks know the mask
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            en_m <= 32'h0;
            rt_m <= 1'b0;
        end else if (i_wr_stb) begin
            if (i_addr == 8'h10) en_m <= en_m | (i_wr_data & 32'hc000_007f);
            if (i_addr == 8'h14) en_m <= en_m & ~i_wr_data;
            if (i_addr == 8'h04) rt_m <= i_wr_data[8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    resv_read_zero_a: assert property (
        $past(i_rd_stb) && $past(i_addr) == 8'h0c
        |-> o_rd_data[31] == 1'b0 && o_rd_data[29:7] == 23'h0)
        else $error("reserved status bits read non-zero");
    owner_req_set_a: assert property (
        i_wr_stb && i_addr == 8'h08 && i_wr_data[3]
        |=> o_owner_change_request)
        else $error("owner request write did not set the flag");
    owner_sticky_a: assert property (
        !i_wr_stb |=> $stable(o_owner_change_request))
        else $error("ownership flag changed without a write");
    owner_clear_a: assert property (
        i_wr_stb && i_addr == 8'h18 && i_wr_data[30]
        |=> !o_owner_change_request)
        else $error("ownership flag survived its clear");
    owner_mgmt_a: assert property (
        o_owner_change_request && en_m[31] && en_m[30] |-> o_mgmt_irq)
        else $error("unmasked ownership change gave no mgmt irq");
    master_off_a: assert property (
        !en_m[31] |-> !o_usb_irq && !o_mgmt_irq)
        else $error("irq raised with global enable off");
    route_excl_a: assert property (
        o_mgmt_irq && !o_owner_change_request |-> !o_usb_irq)
        else $error("event routed to both irq lines");
    fatal_irq_a: assert property (
        i_fatal_error
        |=> o_usb_irq || !(en_m[31] && en_m[4] && !rt_m))
        else $error("fatal error pulse gave no usb irq");
    resume_mgmt_a: assert property (
        i_resume_seen
        |=> o_mgmt_irq || !(en_m[31] && en_m[3] && rt_m))
        else $error("routed resume gave no mgmt irq");
endmodule // uhis_event_status_props

bind uhis_event_status uhis_event_status_props i_props (
    .i_sys_clk, .i_rst, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
    .o_rd_data, .i_fatal_error, .i_resume_seen, .o_usb_irq, .o_mgmt_irq,
    .o_owner_change_request);

// ===== verif/test_usb_host_irq_status.sv
// self-checking bench for the event status block
`timescale 1ns/1ps

module test_usb_host_irq_status;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] hub0 = 32'h0, hub1 = 32'h0, hub2 = 32'h0;
    logic [15:0] frame = 16'h0;
    logic [4:0]  ev = 5'h0;
    wire  [31:0] rdata;
    wire         usb_irq, mgmt_irq, owner_req;
    logic [7:0]  wa = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] st = 32'h0, en = 32'h0;
    logic        rt = 1'b0;
    int          err_count = 0, checked = 0, cycles = 0, i;

    always #25 clk = ~clk;

    uhis_event_status i_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdata),
        .i_hub_status(hub0), .i_hub_port1_status(hub1),
        .i_hub_port2_status(hub2), .i_frame_number(frame),
        .i_fatal_error(ev[4]), .i_resume_seen(ev[3]), .i_frame_start(ev[2]),
        .i_done_written(ev[1]), .i_sched_overrun(ev[0]),
        .o_usb_irq(usb_irq), .o_mgmt_irq(mgmt_irq),
        .o_owner_change_request(owner_req));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one write, event pulses ride in the same cycle; model applies the
    // write first and the events last, so a set beats a clear
    task automatic wr_ev(input logic [7:0] a, input logic [31:0] d,
                         input logic [4:0] e);
        logic u, m;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        ev <= e;
        @(posedge clk);
        wr <= 1'b0;
        ev <= 5'h0;
        case (a)
            8'h04: rt = d[8];
            8'h08: if (d[3]) st[30] = 1'b1;
            8'h0c: st = st & d;
            8'h10: en = en | (d & 32'hc000_007f);
            8'h14: en = en & ~d;
            8'h18: st = st & ~d;
            default: ;
        endcase
        st = st | {27'h0, e};
        #1;
        u = |(st[6:0] & en[6:0]);
        m = en[31] & (st[30] & en[30] | rt & u);
        chk("usb_irq", usb_irq, en[31] & ~rt & u);
        chk("mgmt_irq", mgmt_irq, m);
        chk("owner_req", owner_req, st[30]);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] e;
        case (a)
            8'h04: e = {23'h0, rt, 8'h0};
            8'h08: e = {28'h0, st[30], 3'h0};
            8'h0c: e = st;
            8'h10, 8'h14: e = en;
            default: e = 32'h0;
        endcase
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rd_data", rdata, e);
    endtask

    // hub or frame change; the change detector adds a cycle
    task automatic wiggle(input int k);
        @(posedge clk);
        case (k)
            0: hub0 <= hub0 ^ ($urandom | 32'h1);
            1: hub1 <= hub1 ^ ($urandom | 32'h1);
            2: hub2 <= hub2 ^ ($urandom | 32'h1);
            default: frame <= {~frame[15], 15'($urandom)};
        endcase
        repeat (3) @(posedge clk);
        st[k > 2 ? 5 : 6] = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        i = $urandom(32'h823e);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (i = 4; i <= 32; i += 4) rd_chk(i[7:0]);
        wr_ev(8'h10, 32'hc000_007f, 5'h0);
        rd_chk(8'h14);
        // each pulse sets its flag; ones keep it, a clear removes it;
        // reserved bits are always written as zeros, as software must
        for (i = 0; i < 5; i++) begin
            wr_ev(8'hf0, 32'h0, 5'h1 << i);
            rd_chk(8'h0c);
            wr_ev(8'h0c, 32'h4000_007f, 5'h0);
            rd_chk(8'h0c);
            wd = i[0] ? 32'h1 << i : 32'h4000_007f ^ (32'h1 << i);
            wr_ev(i[0] ? 8'h18 : 8'h0c, wd, 5'h0);
            rd_chk(8'h0c);
        end
        // hub registers, then both edges of the frame wrap bit
        for (i = 0; i < 5; i++) begin
            wiggle(i);
            rd_chk(8'h0c);
            wr_ev(8'h18, 32'h60, 5'h0);
        end
        wr_ev(8'h14, 32'h4000_0000, 5'h0);
        wr_ev(8'h08, 32'h8, 5'h0);
        rd_chk(8'h08);
        rd_chk(8'h0c);
        wr_ev(8'h10, 32'h4000_0000, 5'h0);
        wr_ev(8'h0c, 32'h0000_007f, 5'h0);
        rd_chk(8'h08);
        wr_ev(8'h04, 32'h100, 5'h8);
        rd_chk(8'h04);
        wr_ev(8'h18, 32'h8, 5'h0);
        wr_ev(8'h04, 32'h0, 5'h0);
        wr_ev(8'h18, 32'h4000_007f, 5'h1f);
        rd_chk(8'h0c);
        wr_ev(8'h0c, 32'h0, 5'h4);
        rd_chk(8'h0c);
        wr_ev(8'h14, 32'h8000_0000, 5'h0);
        rd_chk(8'h10);
        // random traffic over every mapped offset, reserved bits zero
        for (i = 0; i < 30; i++) begin
            wa = 8'h04 + 8'(4 * ($urandom % 6));
            case (wa)
                8'h04: wd = $urandom & 32'h0000_0100;
                8'h08: wd = $urandom & 32'h0000_0008;
                8'h10, 8'h14: wd = $urandom & 32'hc000_007f;
                default: wd = $urandom & 32'h4000_007f;
            endcase
            wr_ev(wa, wd, 5'($urandom));
            rd_chk(8'h04 + 8'(4 * ($urandom % 6)));
        end
        final_report();
    end
endmodule // test_usb_host_irq_status
